//--- verilog/dpm_host.sv
// Purpose: AHB-Lite controlled host for one port of a dual-port RAM
// Assumes: Single AHB-Lite master, word accesses, device pins async
// Notes:   Semaphores are freed from this side after every reset
//
// The implementer's own choices: the AHB-Lite slave port and the address map.

`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - semaphore access: array off, select on
// - slave role: busy high normal, low inhibits
// - depth cascade ANDs busy indications externally
// - hold address, enable before write pulse
// - exactly one master part per array
// - flags active low; zero requests, one releases
// - own token only if readback succeeded
// - failed request: reread or withdraw, retry
module dpm_host #(
  parameter bit LEFT_PORT  = 1'b1,   // Port this host drives
  parameter bit HALF_DEPTH = 1'b0    // Smaller device variant
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // RAM port pins
  output dpm_host_pkg::port_pins_t  pins,
  input  wire dpm_host_pkg::data_t  dataIn,
  input  wire logic                 busyIn,      // Busy pin level
  output logic                      busyOut,     // Driven in slave role
  output logic                      busyOe,
  input  wire logic                 mailboxFlagN, // Own mailbox flag
  output logic                      roleMaster,   // Role strap to part
  output logic                      mailboxFlag   // Synced, high = set
);
  import dpm_host_pkg::*;

  typedef enum {
    S_INIT_ISSUE, S_INIT_WAIT, S_IDLE, S_OP_WAIT,
    S_ACQ_W, S_ACQ_R_ISSUE, S_ACQ_R
  } host_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  host_state_t        state_ff;        // Command sequencer
  logic [SEM_SEL_W-1:0] initIdx_ff;    // Semaphore being freed
  op_t                op_ff;           // Stored operation
  logic               sem_ff;          // Target semaphore space
  logic               master_ff;       // Role select
  logic               inhibit_ff;      // Block writes in slave role
  addr_t              addr_ff;         // Target address
  data_t              wdata_ff;        // Write word
  data_t              rdata_ff;        // Last read word
  logic               done_ff;         // Sticky command done
  logic               token_ff;        // Last acquire succeeded
  logic               collide_ff;      // Sticky collision seen
  logic               initDone_ff;     // Free-up sweep finished
  logic               apValid_ff;      // AHB data phase pending write
  logic [7:0]         apAddr_ff;       // Its register offset
  logic [31:0]        hrdata_ff;       // Read data register
  data_t              dinMeta_ff;      // Synchroniser stage one
  data_t              dinS_ff;         // Stage two
  logic [1:0]         busyMeta_ff;     // Busy, mailbox stage one
  logic [1:0]         busyS_ff;        // Stage two
  logic               engDone;
  logic               engCollide;
  logic               engIdle;
  data_t              engRdata;

  // Offset compare, shared by write decode and read mux
  function automatic logic regIs(input logic [7:0] a,
                                 input logic [7:0] off);
    regIs = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers: stage one feeds stage two only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    dinMeta_ff <= dataIn;
    dinS_ff <= dinMeta_ff;
    busyMeta_ff <= {mailboxFlagN, busyIn};
    busyS_ff <= busyMeta_ff;
  end

  // ----------------------------------------------------------------
  // AHB-Lite decode, zero wait states, always OKAY
  // ----------------------------------------------------------------
  wire apTake = hsel && htrans[1] && hready;
  wire [7:0] apOff = haddr[7:0];
  wire wrCtrl = apValid_ff && regIs(apAddr_ff, REG_CTRL);
  wire wrAddr = apValid_ff && regIs(apAddr_ff, REG_ADDR);
  wire wrData = apValid_ff && regIs(apAddr_ff, REG_WDATA);
  wire startReq = wrCtrl && hwdata[CTRL_START];
  wire [31:0] statusWord = {26'h0, initDone_ff, mailboxFlag, collide_ff,
                            token_ff, done_ff, (state_ff != S_IDLE)};
  wire [31:0] ctrlWord = {25'h0, 1'b0, inhibit_ff, master_ff, sem_ff,
                          op_ff, 1'b0};
  wire [31:0] readMux =
    regIs(apOff, REG_CTRL)   ? ctrlWord :
    regIs(apOff, REG_ADDR)   ? {13'h0, addr_ff} :
    regIs(apOff, REG_WDATA)  ? {14'h0, wdata_ff} :
    regIs(apOff, REG_RDATA)  ? {14'h0, rdata_ff} :
    regIs(apOff, REG_STATUS) ? statusWord : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  // Address phase capture and read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      apValid_ff <= 1'b0;
      apAddr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
    end else begin
      apValid_ff <= apTake && hwrite;
      apAddr_ff <= apOff;
      if (apTake && !hwrite) begin
        hrdata_ff <= readMux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request to the cycle engine
  // ----------------------------------------------------------------
  wire idleStart = (state_ff == S_IDLE) && startReq;
  wire startInit = idleStart && hwdata[CTRL_REINIT];
  wire [1:0] newOp = hwdata[CTRL_OP_LO +: 2];
  wire newIsAcq = (newOp == OP_ACQUIRE);
  wire newIsSemOp = newIsAcq || (newOp == OP_RELEASE);
  wire initReq = (state_ff == S_INIT_ISSUE);
  wire acqReadReq = (state_ff == S_ACQ_R_ISSUE);
  wire opReq = idleStart && !startInit;
  wire req = initReq || acqReadReq || opReq;
  wire reqWrite = initReq || (opReq && (newOp != OP_READ));
  wire reqSem = initReq || acqReadReq ||
                (opReq && (newIsSemOp || hwdata[CTRL_SEM]));
  // Only the low lines reach a semaphore; the sweep drives the rest as zero
  wire addr_t reqAddr = initReq ? addr_t'(initIdx_ff) : addr_ff;
  // Zero requests a token, one frees it
  wire data_t reqData = (initReq || (opReq && newOp == OP_RELEASE)) ?
                        '1 :
                        (opReq && newIsAcq) ? '0 : wdata_ff;
  wire acqFinish = (state_ff == S_ACQ_R) && engDone;
  // Sweep counts as finished only after the last flag is freed
  wire initLast = (state_ff == S_INIT_WAIT) && engDone &&
                  (initIdx_ff == SEM_SEL_W'(SEM_CNT - 1));

  port_cycle u_cycle (
    .clk        (clk),
    .rst        (rst),
    .req        (req),
    .isWrite    (reqWrite),
    .isSem      (reqSem),
    .masterRole (master_ff),
    .reqAddr    (reqAddr),
    .reqData    (reqData),
    .busyNS     (busyS_ff[0]),
    .dinS       (dinS_ff),
    .pins       (pins),
    .done       (engDone),
    .rdata      (engRdata),
    .collision  (engCollide),
    .idle       (engIdle)
  );

  // Slave role: busy pin is our write inhibit; master role: input
  assign busyOe = !master_ff;
  assign busyOut = !inhibit_ff;
  assign roleMaster = master_ff;
  assign mailboxFlag = !busyS_ff[1];

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= S_INIT_ISSUE;
      initIdx_ff <= '0;
    end else begin
      case (state_ff)
        S_INIT_ISSUE: state_ff <= S_INIT_WAIT;
        S_INIT_WAIT: if (engDone) begin
          initIdx_ff <= initIdx_ff + 1'b1;
          state_ff <= (initIdx_ff == SEM_SEL_W'(SEM_CNT - 1)) ?
                      S_IDLE : S_INIT_ISSUE;
        end
        S_IDLE: if (startInit) begin
          state_ff <= S_INIT_ISSUE;
          initIdx_ff <= '0;
        end else if (opReq) begin
          state_ff <= newIsAcq ? S_ACQ_W : S_OP_WAIT;
        end
        S_OP_WAIT: if (engDone) state_ff <= S_IDLE;
        S_ACQ_W: if (engDone) state_ff <= S_ACQ_R_ISSUE;
        S_ACQ_R_ISSUE: state_ff <= S_ACQ_R;
        S_ACQ_R: if (engDone) state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // Control registers written by software
  always_ff @(posedge clk) begin
    if (rst) begin
      op_ff <= OP_READ;
      sem_ff <= 1'b0;
      master_ff <= 1'b0;
      inhibit_ff <= 1'b0;
      addr_ff <= '0;
      wdata_ff <= '0;
    end else begin
      if (wrCtrl) begin
        op_ff <= op_t'(newOp);
        sem_ff <= hwdata[CTRL_SEM];
        master_ff <= hwdata[CTRL_MASTER];
        inhibit_ff <= hwdata[CTRL_INHIBIT];
      end
      if (wrAddr) addr_ff <= hwdata[ADDR_W-1:0];
      if (wrData) wdata_ff <= hwdata[DATA_W-1:0];
    end
  end

  // Status: event set wins over the clear made by a new start
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= '0;
      done_ff <= 1'b0;
      token_ff <= 1'b0;
      collide_ff <= 1'b0;
      initDone_ff <= 1'b0;
    end else begin
      if (engDone && state_ff == S_OP_WAIT && op_ff == OP_READ) begin
        rdata_ff <= engRdata;
      end
      if (acqFinish) begin
        rdata_ff <= engRdata;
        token_ff <= !engRdata[0];
      end else if (opReq && newOp == OP_RELEASE) begin
        token_ff <= 1'b0;
      end
      done_ff <= (engDone && state_ff != S_INIT_WAIT) ||
                 (done_ff && !idleStart);
      collide_ff <= engCollide || (collide_ff && !idleStart);
      if (initLast) initDone_ff <= 1'b1;
      else if (startInit) initDone_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_slave_busy_drive: assert property (
    wrCtrl && !hwdata[CTRL_MASTER] && hwdata[CTRL_INHIBIT] |=>
      busyOe && !busyOut)
    else $error("slave inhibit not driven low");

  a_acquire_writes_zero: assert property (
    $rose(state_ff == S_ACQ_W) |->
      $past(req && reqWrite && reqSem && reqData == '0))
    else $error("acquire did not write a zero");

  a_token_from_readback: assert property (
    $rose(token_ff) |-> $past(acqFinish && !engRdata[0]))
    else $error("token claimed without readback");

  a_failed_no_token: assert property (
    acqFinish && engRdata[0] |=> !token_ff && state_ff == S_IDLE)
    else $error("failed request kept token");

  a_init_frees_flags: assert property (
    state_ff == S_INIT_ISSUE |->
      req && reqWrite && reqSem && reqData == '1 && engIdle)
    else $error("free-up sweep wrote wrong value");

  initial begin
    if (ADDR_W != 19 || DATA_W != 18 || SEM_CNT != 8) begin
      $error("unsupported port geometry");
    end
  end

endmodule

`default_nettype wire

//--- verilog/dpm_host_pkg.sv
// Purpose: Shared constants and carriers for the dual-port RAM port host
// Assumes: 200 MHz clock, one RAM port driven through its pins
// Notes:   Register offsets are byte addresses of 32-bit words

package dpm_host_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;                 // Full-depth address lines
  localparam int DATA_W = 18;                 // One word of the array
  localparam int SEM_CNT = 8;                 // Semaphore flags per device
  localparam int SEM_SEL_W = 3;               // Low address lines for them
  localparam int SYNC_STAGES = 2;             // Pin synchroniser depth

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

  // ----------------------------------------------------------------
  // Mailbox locations, full and half depth
  // ----------------------------------------------------------------
  localparam addr_t MBOX_LEFT_FULL = 19'h7fffe;  // Raises left flag
  localparam addr_t MBOX_RIGHT_FULL = 19'h7ffff; // Raises right flag
  localparam addr_t MBOX_LEFT_HALF = 19'h3fffe;
  localparam addr_t MBOX_RIGHT_HALF = 19'h3ffff;

  // ----------------------------------------------------------------
  // Timing, in ns and derived cycles
  // ----------------------------------------------------------------
  localparam int CLK_NS = 5;
  localparam int T_SETUP_NS = 15;     // Address/enable before write pulse
  localparam int T_PULSE_NS = 15;     // Write pulse width
  localparam int T_ACCESS_NS = 15;    // Read access time
  localparam int T_RECOVER_NS = 5;    // Hold after strobe removed
  localparam int SETUP_CYC =
    (T_SETUP_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC =
    (T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int HOLD_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int CTRL_START = 0;
  localparam int CTRL_OP_LO = 1;      // Two bits of operation
  localparam int CTRL_SEM = 3;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_INHIBIT = 5;
  localparam int CTRL_REINIT = 6;

  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TOKEN = 2;
  localparam int ST_COLLIDE = 3;
  localparam int ST_MAILBOX = 4;
  localparam int ST_INITDONE = 5;

  typedef enum logic [1:0] {
    OP_READ, OP_WRITE, OP_ACQUIRE, OP_RELEASE
  } op_t;

  // ----------------------------------------------------------------
  // Pins driven toward the RAM port
  // ----------------------------------------------------------------
  typedef struct packed {
    addr_t addr;              // Address lines
    data_t dout;              // Data driven on writes
    logic  dataOe;            // Data pins driven
    logic  arrayEnableLowN;   // Array chip enable, active low
    logic  arrayEnableHigh;   // Secondary enable, active high
    logic  tokenSpaceSelectN; // Semaphore space select, active low
    logic  outEnN;            // Output enable, active low
    logic  readWriteN;        // Low for write
  } port_pins_t;

endpackage

//--- verilog/port_cycle.sv
// Purpose: Runs one SRAM-style cycle on the RAM port pins
// Assumes: Busy and data inputs already synchronised by the caller
// Notes:   Accepts a request only while idle

`timescale 1ns/10ps
`default_nettype none

module port_cycle (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 req,        // Start, idle only
  input  wire logic                 isWrite,
  input  wire logic                 isSem,
  input  wire logic                 masterRole,
  input  wire dpm_host_pkg::addr_t  reqAddr,
  input  wire dpm_host_pkg::data_t  reqData,
  input  wire logic                 busyNS,     // Synced busy, low = hit
  input  wire dpm_host_pkg::data_t  dinS,       // Synced data pins
  output dpm_host_pkg::port_pins_t  pins,
  output logic                      done,       // Last cycle pulse
  output dpm_host_pkg::data_t       rdata,
  output logic                      collision,  // Stalled on busy
  output logic                      idle
);
  import dpm_host_pkg::*;

  typedef enum {C_IDLE, C_SETUP, C_PULSE, C_HOLD} cyc_state_t;

  cyc_state_t             state_ff;     // Cycle phase
  logic [CNT_W-1:0]       cnt_ff;       // Phase countdown
  logic                   wr_ff;        // Latched direction
  logic                   sem_ff;       // Latched space
  addr_t                  addr_ff;      // Address held for whole cycle
  data_t                  data_ff;      // Write data held
  data_t                  rdata_ff;     // Captured read word
  logic [CNT_W-1:0]       stable_ff;    // Helper: cycles in setup

  wire inCycle = (state_ff != C_IDLE);
  wire cntZero = (cnt_ff == '0);
  // Writes wait while the master reports a clash on an array word
  wire stall = wr_ff && !sem_ff && masterRole && !busyNS;
  wire setupEnd = (state_ff == C_SETUP) && cntZero && !stall;

  // ----------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------
  assign pins.addr = addr_ff;
  assign pins.dout = data_ff;
  assign pins.dataOe = inCycle && wr_ff;
  // Semaphore space: array enable off, secondary off, select on
  assign pins.arrayEnableLowN = !(inCycle && !sem_ff);
  assign pins.arrayEnableHigh = !(inCycle && sem_ff);
  assign pins.tokenSpaceSelectN = !(inCycle && sem_ff);
  assign pins.outEnN = !(inCycle && !wr_ff);
  assign pins.readWriteN = !((state_ff == C_PULSE) && wr_ff);
  assign done = (state_ff == C_HOLD) && cntZero;
  assign rdata = rdata_ff;
  assign collision = (state_ff == C_SETUP) && cntZero && stall;
  assign idle = !inCycle;

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= C_IDLE;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        C_IDLE: if (req) begin
          state_ff <= C_SETUP;
          cnt_ff <= isWrite ? CNT_W'(SETUP_CYC - 1) : CNT_W'(READ_CYC - 1);
        end
        C_SETUP: if (!cntZero) begin
          cnt_ff <= cnt_ff - 1'b1;
        end else if (!stall) begin
          state_ff <= wr_ff ? C_PULSE : C_HOLD;
          cnt_ff <= wr_ff ? CNT_W'(PULSE_CYC - 1) : CNT_W'(HOLD_CYC - 1);
        end
        C_PULSE: if (cntZero) begin
          state_ff <= C_HOLD;
          cnt_ff <= CNT_W'(HOLD_CYC - 1);
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        C_HOLD: if (cntZero) begin
          state_ff <= C_IDLE;
        end else begin
          cnt_ff <= cnt_ff - 1'b1;
        end
        default: state_ff <= C_IDLE;
      endcase
    end
  end

  // Request latch and read capture; data path also cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ff <= 1'b0;
      sem_ff <= 1'b0;
      addr_ff <= '0;
      data_ff <= '0;
      rdata_ff <= '0;
    end else begin
      if (req && !inCycle) begin
        wr_ff <= isWrite;
        sem_ff <= isSem;
        addr_ff <= reqAddr;
        data_ff <= reqData;
      end
      if (setupEnd && !wr_ff) begin
        rdata_ff <= dinS;
      end
    end
  end

  // Helper for the setup check only
  always_ff @(posedge clk) begin
    if (rst || state_ff != C_SETUP) begin
      stable_ff <= '0;
    end else begin
      stable_ff <= stable_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sem_pin_levels: assert property (
    !pins.tokenSpaceSelectN |->
      pins.arrayEnableLowN && !pins.arrayEnableHigh && sem_ff)
    else $error("semaphore access with array enabled");

  a_setup_before_strobe: assert property (
    $fell(pins.readWriteN) |->
      $past(stable_ff) >= CNT_W'(SETUP_CYC - 1) && $stable(pins.addr))
    else $error("write pulse before address settled");

  a_busy_stalls_write: assert property (
    (state_ff == C_SETUP) && stall |=> pins.readWriteN)
    else $error("write pulse started during collision");

endmodule

`default_nettype wire

//--- tb/dpm_port_model.sv
// Purpose: Behavioural far side of one RAM port (host on the left)
// Assumes: Opposite port activity is commanded by the bench
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module dpm_port_model (
  input  wire dpm_host_pkg::port_pins_t pins,
  input  wire logic                     busyW,     // Busy pin level
  input  wire logic                     clash,     // Other side on word
  input  wire logic                     raiseMb,   // Other side mails
  input  wire logic [7:0]               otherHeld,
  output dpm_host_pkg::data_t           dataIn,
  output logic                          modelBusyN,
  output logic                          mailboxFlagN
);
  import dpm_host_pkg::*;
  // ----------------------------------------------------------------
  // Storage; latches start free as power-up software would leave them
  // ----------------------------------------------------------------
  data_t      mem [0:(1<<ADDR_W)-1];
  logic [7:0] semReq = 8'hff;
  data_t      last = '0;
  logic [7:0] semSnap = 8'hff; // Flags as seen by a read
  logic       rightFlagN = 1'b1; // Opposite side's mailbox flag
  wire logic  arrOn = !pins.arrayEnableLowN && pins.arrayEnableHigh;
  // Semaphore space: array enable high, secondary low, select low
  wire logic  semOn = !pins.tokenSpaceSelectN && pins.arrayEnableLowN &&
                      !pins.arrayEnableHigh;
  wire logic [2:0] semIdx = pins.addr[2:0];
  wire logic  semBit = semSnap[semIdx];
  // Flags track both latches except while a read of them runs
  always @(semReq or otherHeld or pins.outEnN or semOn)
    if (pins.outEnN || !semOn) semSnap = semReq | otherHeld;
  wire logic  drive = !pins.outEnN && (arrOn || semOn);
  wire data_t rdVal = semOn ? {DATA_W{semBit}} : mem[pins.addr];
  // Collision only while this port is enabled on the shared word
  assign modelBusyN = !(clash && arrOn);
  assign dataIn = drive ? rdVal : ~last;
  always @(rdVal or drive) if (drive) last = rdVal;
  // Write lands at the end of the strobe; array writes blocked while busy is low
  always @(posedge pins.readWriteN) begin
    if (arrOn && busyW) mem[pins.addr] = pins.dout;
    if (semOn) semReq[semIdx] = pins.dout[0];
    if (arrOn && busyW && pins.addr == MBOX_RIGHT_FULL) rightFlagN = 1'b0;
  end
  initial mailboxFlagN = 1'b1;
  // Level based so enable and address order within a step cannot matter
  wire logic  mbClear = arrOn && !pins.outEnN && pins.addr == MBOX_LEFT_FULL;
  always @(raiseMb or mbClear)
    if (raiseMb) mailboxFlagN = 1'b0;
    else if (mbClear) mailboxFlagN = 1'b1;
endmodule
`default_nettype wire

//--- tb/dpm_host_tb.sv
// Purpose: Self-checking bench for the AHB-Lite RAM port host
// Assumes: Partner model stands in for the RAM's left port
// Notes:   Busy pin level is resolved here from both drivers
`timescale 1ns/10ps
`default_nettype none
module dpm_host_tb;
  import dpm_host_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, clash = 0, raiseMb = 0;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  otherHeld = '0;
  int errTotal = 0, samplesChecked = 0, cyc = 0;
  wire logic hreadyout, hresp, busyOut, busyOe, modelBusyN, mailboxFlagN;
  wire logic roleMaster, mailboxFlag;
  wire logic hready = hreadyout;
  wire logic [31:0] hrdata;
  wire port_pins_t pins;
  wire data_t dataIn;
  // Master drives busy from the part, slave from the host
  wire logic busyW = roleMaster ? modelBusyN : (busyOe ? busyOut : 1'b1);
  dpm_host DUT (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pins, .dataIn,
    .busyIn(busyW), .busyOut, .busyOe, .mailboxFlagN, .roleMaster,
    .mailboxFlag);
  dpm_port_model partner (.pins, .busyW, .clash, .raiseMb, .otherHeld,
    .dataIn, .modelBusyN, .mailboxFlagN);
  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Start a command, then poll until done and idle
  task automatic cmd(input logic [31:0] a, d, ctrl);
    xfer(1, 32'h4, a);
    xfer(1, 32'h8, d);
    xfer(1, 32'h0, ctrl);
    for (int i = 0; i < 300; i++) begin
      xfer(0, 32'h10, 0);
      if (q[1] === 1'b1 && q[0] === 1'b0) break;
    end
    chk(q[1:0], 2'b10);
  endtask
  task automatic reportAndStop;
    $display("checks=%0d mismatches=%0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tInit;
    for (int i = 0; i < 300 && q[5] !== 1'b1; i++) xfer(0, 32'h10, 0);
    chk(q[5], 1);
    chk(partner.semReq, 8'hff);
    xfer(0, 32'h14, 0);
    chk(q, 0);
    chk(hresp, 0);
    cmd(32'h3, 0, 32'hd);
    chk(partner.semReq, 8'hf7);
    xfer(1, 32'h0, 32'h41);
    q = '0;
    for (int i = 0; i < 300 && q[5] !== 1'b1; i++) xfer(0, 32'h10, 0);
    chk({partner.semReq, q[5]}, 9'h1ff);
    $display("test init done");
  endtask
  task automatic tMail;
    raiseMb <= 1'b1;
    @(posedge clk);
    raiseMb <= 1'b0;
    cmd(32'h7fffe, 32'h2a5c3, 32'h3);
    chk({q[4], mailboxFlag}, 2'b11);
    cmd(32'h7ffff, 32'h5, 32'h3);
    chk(partner.rightFlagN, 0);
    cmd(32'h7fffe, 32'h1111, 32'h23);
    cmd(32'h7fffe, 0, 32'h1);
    xfer(0, 32'hc, 0);
    chk(q, 32'h2a5c3);
    xfer(0, 32'h10, 0);
    chk({q[4], mailboxFlag}, 0);
    $display("test mailbox done");
  endtask
  task automatic tSem;
    for (int i = 0; i < 8; i++) begin
      otherHeld <= 8'h1 << ((i + 1) % 8);
      cmd(32'h7fff8 | i, 0, 32'hd);
      chk(q[2], 1);
      chk(partner.semReq[i], 0);
      cmd(32'h7fff8 | ((i + 1) % 8), 0, 32'hd);
      chk(q[2], 0);
      cmd(32'h7fff8 | i, 32'h3ffff, 32'hf);
      chk(partner.semReq[i], 1);
    end
    $display("test semaphore done");
  endtask
  task automatic tBusy;
    clash <= 1'b1;
    xfer(1, 32'h4, 32'h100);
    xfer(1, 32'h8, 32'h155aa);
    xfer(1, 32'h0, 32'h13);
    repeat (20) @(posedge clk);
    chk(pins.readWriteN, 1);
    chk(roleMaster, 1);
    xfer(0, 32'h10, 0);
    chk(q[3:0], 4'h9);
    clash <= 1'b0;
    cmd(32'h100, 0, 32'h1);
    xfer(0, 32'hc, 0);
    chk(q, 32'h155aa);
    $display("test busy done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errTotal++;
      reportAndStop;
    end
  end
  initial begin
    q = '0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tInit;
    tMail;
    tSem;
    tBusy;
    reportAndStop;
  end
endmodule
`default_nettype wire
